// ==== rtl/tpp_consts.vh ====
`ifndef TPP_CONSTS_VH
`define TPP_CONSTS_VH
// Register indices (byte address divided by four)
`define TPP_IDX_CNT_LOW     3'h0
`define TPP_IDX_CTRL_A      3'h1
`define TPP_IDX_CTRL_B      3'h2
`define TPP_IDX_DUTY_LOW    3'h3
`define TPP_IDX_PRESC_CNT   3'h4
`define TPP_IDX_HIGH_BITS   3'h5
`define TPP_IDX_STATUS      3'h6
`define TPP_IDX_MISC        3'h7
// Control A fields
`define TPP_A_RUN           0
`define TPP_A_RELOAD        1
`define TPP_A_ONESHOT       2
`define TPP_A_PWM_LOW       6
`define TPP_A_PWM_OE        7
// Control B fields
`define TPP_B_RATE_LSB      0
`define TPP_B_PRESC_DIS_N   3
`define TPP_B_EDGE          4
`define TPP_B_SRC           5
// High bits register fields
`define TPP_H_DUTY_LSB      0
`define TPP_H_TMR_LSB       4
// Misc register fields
`define TPP_M_HOSC          0
// Reset values
`define TPP_RST_CTRL_A      8'h00
`define TPP_RST_CTRL_B      8'h3F
`define TPP_RST_PRESC       8'hFF
`define TPP_RST_HIGH        8'h00
`define TPP_RST_DUTY        8'h00
`define TPP_RST_CNT         10'h000
`define TPP_RST_RELOAD      10'h3FF
`define TPP_ALL_ONES        10'h3FF
// AXI responses
`define TPP_RESP_OKAY       2'h0
`define TPP_RESP_SLVERR     2'h2
`endif

// ==== rtl/tpp_prescaler.v ====
`include "tpp_consts.vh"
module tpp_prescaler (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Control
	input  wire       tick_in,
	input  wire       bypass,
	input  wire [2:0] rate_sel,
	// Result
	output reg        tick_out,
	output reg  [7:0] count_r
);
	// Division 2^(sel+1): done when the low sel+1 bits of the down counter are zero
	function [7:0] tpp_mask;
		input [2:0] sel;
		begin
			tpp_mask = (8'h02 << sel) - 8'h01;
		end
	endfunction

	wire done = ((count_r & tpp_mask(rate_sel)) == 8'h00);

	always @(posedge aclk) begin
		if (!aresetn) begin
			count_r  <= `TPP_RST_PRESC;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (bypass) begin
				tick_out <= tick_in;
			end else if (tick_in) begin
				count_r  <= count_r - 8'h01;
				tick_out <= done;
			end
		end
	end
endmodule // tpp_prescaler

// ==== rtl/tpp_timer.v ====
// Functional notes
// - Count read returns live low 8 bits of the count.
// - Count write stores reload, loads counter now.
// - Counts only while run enable set.
// - Reload-select 0: underflow reloads all ones.
// - Reload-select 1: underflow reloads stored value.
// - One-shot counts to zero, then stops.
// - Polarity bit one makes PWM active low.
// - Output enable routes PWM onto pin.
// - Reload value sets PWM frame period.
// - Duty is high bits above duty byte.
// - Rate field divides by 2^(field+1).
// - Disable bit bypasses prescaler; change rate disabled.
// - Edge bit picks falling or rising edge.
// - Source bit picks external pin or instruction.
// - Prescaler count readable, resets all ones.
// - Underflow sets flag until software clears.
// - High bits: write reload, read count.
// - High oscillator select overrides source bit.
`include "tpp_consts.vh"
module tpp_timer (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Clock sources
	input  wire        instr_tick,
	input  wire        high_osc_tick,
	input  wire        external_clock_pin,
	// Shared pin
	input  wire        port_pin_two_gpio_out,
	input  wire        port_pin_two_gpio_oe,
	output reg         port_pin_two_out,
	output reg         port_pin_two_oe,
	// Event
	output reg         underflow_event_flag
);
	reg  [7:0] ctrl_a_r;
	reg  [7:0] ctrl_b_r;
	reg  [7:0] duty_low_r;
	reg  [7:0] high_r;
	reg        hosc_sel_r;
	reg  [9:0] reload_r;
	reg  [9:0] count_r;
	reg  [9:0] count_nxt;
	reg        stopped_r;
	reg  [2:0] ext_sync_r;
	reg  [4:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg  [3:0] w_strb_r;
	reg        aw_have_r;
	reg        w_have_r;
	wire [7:0] presc_cnt;
	wire       timer_tick;

	// Lane 0 write to one register index
	function tpp_wr_hit;
		input       fire;
		input [3:0] strb;
		input [2:0] sel;
		input [2:0] idx;
		begin
			tpp_wr_hit = fire & strb[0] & (sel == idx);
		end
	endfunction

	// Two high bits above a low byte
	function [9:0] tpp_join;
		input [1:0] hi;
		input [7:0] lo;
		begin
			tpp_join = {hi, lo};
		end
	endfunction

	wire run_en     = ctrl_a_r[`TPP_A_RUN];
	wire reload_sel = ctrl_a_r[`TPP_A_RELOAD];
	wire one_shot   = ctrl_a_r[`TPP_A_ONESHOT];
	wire [9:0] duty = tpp_join(high_r[`TPP_H_DUTY_LSB+1:`TPP_H_DUTY_LSB], duty_low_r);

	// Two flops before the edge detector; third stage holds the prior sample
	// No reset: stages follow the pin, so release never shows a false edge
	always @(posedge aclk) begin
		ext_sync_r <= {ext_sync_r[1:0], external_clock_pin};
	end
	wire ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
	wire ext_fall = ~ext_sync_r[1] & ext_sync_r[2];
	wire ext_tick = ctrl_b_r[`TPP_B_EDGE] ? ext_fall : ext_rise;
	wire src_tick = hosc_sel_r ? high_osc_tick :
		(ctrl_b_r[`TPP_B_SRC] ? ext_tick : instr_tick);

	tpp_prescaler u_presc (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (src_tick & run_en & ~stopped_r),
		.bypass   (ctrl_b_r[`TPP_B_PRESC_DIS_N]),
		.rate_sel (ctrl_b_r[2:0]),
		.tick_out (timer_tick),
		.count_r  (presc_cnt)
	);

	// Bus write decode
	wire wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
	wire [2:0] wr_idx = aw_addr_r[4:2];
	wire wr_cnt = tpp_wr_hit(wr_fire, w_strb_r, wr_idx, `TPP_IDX_CNT_LOW);
	wire wr_hi  = tpp_wr_hit(wr_fire, w_strb_r, wr_idx, `TPP_IDX_HIGH_BITS);
	wire wr_clr = tpp_wr_hit(wr_fire, w_strb_r, wr_idx, `TPP_IDX_STATUS) & w_data_r[0];
	wire [9:0] reload_new = tpp_join(high_r[`TPP_H_TMR_LSB+1:`TPP_H_TMR_LSB], w_data_r[7:0]);
	wire underflow = timer_tick & run_en & ~stopped_r & (count_r == 10'h000);

	always @* begin
		count_nxt = count_r;
		if (wr_cnt) begin
			count_nxt = reload_new;
		end else if (timer_tick && run_en && !stopped_r) begin
			if (count_r != 10'h000) begin
				count_nxt = count_r - 10'h001;
			end else if (one_shot) begin
				count_nxt = count_r;
			end else if (reload_sel) begin
				count_nxt = reload_r;
			end else begin
				count_nxt = `TPP_ALL_ONES;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			count_r              <= `TPP_RST_CNT;
			reload_r             <= `TPP_RST_RELOAD;
			stopped_r            <= 1'b0;
			underflow_event_flag <= 1'b0;
			port_pin_two_out     <= 1'b0;
			port_pin_two_oe      <= 1'b0;
		end else begin
			count_r <= count_nxt;
			if (wr_cnt) begin
				reload_r <= reload_new;
			end else if (wr_hi) begin
				reload_r[9:8] <= w_data_r[`TPP_H_TMR_LSB+1:`TPP_H_TMR_LSB];
			end
			// One-shot parks at zero until rewritten or re-enabled
			if (wr_cnt || !run_en || !one_shot) begin
				stopped_r <= 1'b0;
			end else if (underflow) begin
				stopped_r <= 1'b1;
			end
			// Set beats a clear in the same cycle
			if (underflow) begin
				underflow_event_flag <= 1'b1;
			end else if (wr_clr) begin
				underflow_event_flag <= 1'b0;
			end
			// Frame period is the reload cycle of the counter
			if (ctrl_a_r[`TPP_A_PWM_OE]) begin
				port_pin_two_out <= ((count_r < duty) ^ ctrl_a_r[`TPP_A_PWM_LOW]);
				port_pin_two_oe  <= 1'b1;
			end else begin
				port_pin_two_out <= port_pin_two_gpio_out;
				port_pin_two_oe  <= port_pin_two_gpio_oe;
			end
		end
	end

	// Register writes and write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_a_r      <= `TPP_RST_CTRL_A;
			ctrl_b_r      <= `TPP_RST_CTRL_B;
			duty_low_r    <= `TPP_RST_DUTY;
			high_r        <= `TPP_RST_HIGH;
			hosc_sel_r    <= 1'b0;
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_addr_r     <= 5'h00;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TPP_RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && !aw_have_r && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_r && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `TPP_RESP_OKAY;
				if (w_strb_r[0]) begin
					case (wr_idx)
						`TPP_IDX_CTRL_A: begin
							ctrl_a_r <= w_data_r[7:0];
						end
						`TPP_IDX_CTRL_B: begin
							ctrl_b_r <= {2'b00, w_data_r[5:0]};
						end
						`TPP_IDX_DUTY_LOW: begin
							duty_low_r <= w_data_r[7:0];
						end
						`TPP_IDX_HIGH_BITS: begin
							high_r <= {2'b00, w_data_r[5:0]};
						end
						`TPP_IDX_MISC: begin
							hosc_sel_r <= w_data_r[`TPP_M_HOSC];
						end
						default: begin
						end
					endcase
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `TPP_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `TPP_RESP_OKAY;
				case (s_axi_araddr[4:2])
					`TPP_IDX_CNT_LOW: begin
						s_axi_rdata <= {24'h000000, count_r[7:0]};
					end
					`TPP_IDX_CTRL_A: begin
						s_axi_rdata <= {29'h00000000, ctrl_a_r[2:0]};
					end
					`TPP_IDX_CTRL_B: begin
						s_axi_rdata <= {24'h000000, ctrl_b_r};
					end
					`TPP_IDX_PRESC_CNT: begin
						s_axi_rdata <= {24'h000000, presc_cnt};
					end
					`TPP_IDX_HIGH_BITS: begin
						s_axi_rdata <= {26'h0000000, count_r[9:8], high_r[3:0]};
					end
					`TPP_IDX_STATUS: begin
						s_axi_rdata <= {31'h00000000, underflow_event_flag};
					end
					`TPP_IDX_MISC: begin
						s_axi_rdata <= {31'h00000000, hosc_sel_r};
					end
					default: begin
						// Duty low byte is write-only
						s_axi_rdata <= 32'h0000_0000;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // tpp_timer

// ==== verif/testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, instr_tick = 0, high_osc_tick = 0, go = 0;
	logic port_pin_two_gpio_out = 0, port_pin_two_gpio_oe = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'hDFCC;
	logic [3:0] s_axi_wstrb = 4'hF, toggles = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, hb = 0;
	logic port_pin_two_out, port_pin_two_oe, underflow_event_flag, external_clock_pin, pin_level;
	int err_count = 0, cmp_count = 0, cyc = 0;
	tpp_timer uut (.*);
	tpp_pin_model pm (.*);
	always #12.5 aclk = !aclk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int edges(int t, fall, lvl);
		return (fall == lvl) ? (t + 1) / 2 : t / 2;
	endfunction
	task ck(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task report_and_stop;
		$display("mismatches %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task wr(input [4:0] a, input [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
	endtask
	task rd(input [4:0] a, output [7:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[7:0];
		s_axi_rready <= 0;
	endtask
	task ld(input [9:0] v);
		wr(5'h14, {2'b00, v[9:8], 2'b00, hb});
		wr(5'h00, v[7:0]);
	endtask
	// Kind 0 instruction, 1 high oscillator, 2 external pin frame
	task tk(input int n, h);
		if (h == 2) begin
			@(posedge aclk);
			go <= 1;
			toggles <= 4'(n);
			@(posedge aclk);
			go <= 0;
			repeat (4 * n + 8) @(posedge aclk);
		end else repeat (n) begin
			@(posedge aclk);
			instr_tick <= (h == 0);
			high_osc_tick <= (h == 1);
			@(posedge aclk);
			instr_tick <= 0;
			high_osc_tick <= 0;
		end
		repeat (6) @(posedge aclk);
	endtask
	task run(input [7:0] a, input [9:0] v, input int n, h, input [9:0] e);
		logic [7:0] lo, hi;
		wr(5'h04, a);
		ld(v);
		tk(n, h);
		rd(5'h00, lo);
		rd(5'h14, hi);
		ck({hi[5:4], lo}, e);
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			report_and_stop;
		end
	end
	initial begin
		logic [9:0] c, d;
		logic [7:0] v, q;
		int m, n, p, lvl;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rd(5'h08, v);
		ck(v, 8'h3F);
		rd(5'h10, v);
		ck(v, 8'hFF);
		rd(5'h04, v);
		ck(v, 8'h00);
		wr(5'h08, 8'h08);
		run(1, 2, 3, 0, 10'h3FF);
		ck(underflow_event_flag, 1);
		rd(5'h18, v);
		ck(v[0], 1);
		wr(5'h18, 1);
		rd(5'h18, v);
		ck(v[0], 0);
		ck(underflow_event_flag, 0);
		n = xs() % 14 + 1;
		run(3, n, n + 1, 0, n);
		run(2, n, 5, 0, n);
		run(5, 3, 6, 0, 0);
		c = 10'(xs() % 900 + 50);
		m = xs() % 40 + 1;
		run(1, c, m, 0, c - m);
		wr(5'h1C, 1);
		run(1, c, m, 1, c - m);
		wr(5'h1C, 0);
		for (p = 0; p < 8; p++) begin
			wr(5'h08, 8'(8 | p));
			wr(5'h08, 8'(p));
			rd(5'h10, q);
			m = xs() % 3 + 1;
			run(1, 10'h200, m << (p + 1), 0, 10'h200 - m);
			rd(5'h10, v);
			ck(v, 8'(q - (m << (p + 1))));
			wr(5'h08, 8'(8 | p));
		end
		lvl = 0;
		for (p = 0; p < 2; p++) begin
			wr(5'h08, 8'(8'h28 | p << 4));
			run(1, 10'h100, 5, 2, 10'h100 - edges(5, p, lvl));
			lvl ^= 1;
		end
		// Reload mode frame: count walks c down to 0, then c again
		wr(5'h08, 8'h08);
		wr(5'h0C, 8'h02);
		c = 10'(xs() % 6 + 2);
		ld(c);
		wr(5'h04, 8'h83);
		for (p = 1; p < 12; p++) begin
			tk(1, 0);
			ck(pin_level, (c - p % (c + 1)) < 2);
		end
		for (p = 0; p < 4; p++) begin
			c = 10'(xs());
			d = p == 0 ? c : 10'(xs());
			hb = d[9:8];
			wr(5'h0C, d[7:0]);
			wr(5'h04, 8'(8'h80 | (p & 1) << 6));
			ld(c);
			repeat (3) @(posedge aclk);
			ck(pin_level, (c < d) ^ p[0]);
			v = 8'(xs());
			port_pin_two_gpio_out <= v[0];
			port_pin_two_gpio_oe <= v[1];
			wr(5'h04, 8'h00);
			repeat (3) @(posedge aclk);
			ck(pin_level, v[1] ? v[0] : 1'b1);
		end
		report_and_stop;
	end
endmodule // testbench

// ==== verif/tpp_checker.sv ====
module tpp_checker (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// AXI handshakes
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	// Responses and data
	input logic [1:0]  s_axi_bresp,
	input logic [1:0]  s_axi_rresp,
	input logic [31:0] s_axi_rdata,
	// Event
	input logic        underflow_event_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence aw_take;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (aw_take |-> ##[1:4] s_axi_bvalid)
		else $error("write not answered");
	a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_read_answer: assert property (ar_take |=> s_axi_rvalid && s_axi_rresp == 2'h0)
		else $error("read not answered");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	// Flag only falls on a software clear
	a_flag_sticky: assert property ($fell(underflow_event_flag)
		|-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
		else $error("flag lost without clear");
	a_reset_idle: assert property (disable iff (1'b0) !aresetn
		|=> !s_axi_bvalid && !s_axi_rvalid && !underflow_event_flag)
		else $error("outputs busy in reset");
endmodule // tpp_checker
bind tpp_timer tpp_checker chk (.*);

// ==== verif/tpp_pin_model.sv ====
module tpp_pin_model (
	// Frame request
	input  logic       aclk,
	input  logic       go,
	input  logic [3:0] toggles,
	// Pin side
	input  logic       port_pin_two_out,
	input  logic       port_pin_two_oe,
	output logic       external_clock_pin,
	output logic       pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] left = 4'h0;
	logic [1:0] ph = 2'h0;
	// Weak pull-up when nobody drives the pin
	assign pin_level = port_pin_two_oe ? port_pin_two_out : 1'b1;
	initial external_clock_pin = 1'b0;
	// Source stands still between frames
	always @(posedge aclk) begin
		ph <= ph + 2'h1;
		if (go) begin
			left <= toggles;
		end else if (left != 4'h0 && ph == 2'h0) begin
			external_clock_pin <= !external_clock_pin;
			left <= left - 4'h1;
		end
	end
endmodule // tpp_pin_model
